/* rtl/dual_serial_host_register_port.sv */
// spi or i2c slave port turning an external master's transfers into register requests
// Contract
// - strap pin picks link once after reset
// - one register per transfer, no increment
// - spi frame: 7 address, direction, 8 data
// - direction one writes, zero reads
// - miso floats unselected, else low except data
// - spi fields shift most significant first
// - select high resets spi shift logic
// - capture on sclk rise, change on fall
// - sda change during scl high aborts
// - detect start and stop conditions
// - repeated start opens new addressed phase
// - eight bits msb first, ninth clock acknowledges
// - answer to slave address 2dh
// - acknowledge only own address, bit picks direction
// - write: address, register, data, all acknowledged; data gets a nack while the buffer is full
// - read: register, restart, one byte out
// - transfers only once soft start done
`timescale 1ns/10ps
`include "serial_port_consts.svh"
module dual_serial_host_register_port #(
   parameter int FIFO_DEPTH = `REQ_FIFO_DEPTH // write request buffer depth
) (
   input wire logic core_clk,                 // system clock, 100 mhz
   input wire logic arst_n,                   // asynchronous reset, active low
   input wire logic ifSelect,                 // interface strap pin
   input wire logic portEnable,               // high after soft start
   input wire logic sclk,                     // spi clock from master
   input wire logic mosi,                     // spi data from master
   input wire logic spiSelectN,               // spi slave select, active low
   output logic misoOut,                      // spi data to master
   output logic misoOeN,                      // miso driven while low
   input wire logic scl,                      // i2c clock from master
   input wire logic sdaIn,                    // i2c data wire level
   output logic sdaOut,                       // i2c data drive value
   output logic sdaOeN,                       // sda pulled while low
   output logic [7:0] rdAddr,                 // register being read
   input wire logic [7:0] rdData,             // contents of rdAddr
   output logic reqValid,                     // write request waiting
   input wire logic reqReady,                 // register file takes it
   output logic [7:0] reqAddr,                // write request address
   output logic [7:0] reqData,                // write request data
   output logic spiOverrun,                   // spi write lost, one cycle
   output serial_port_pkg::port_mode_e ifMode // captured link
);
   import serial_port_pkg::*;

   port_state_s st;      // registered state
   port_state_s next_st; // next state

   logic [`PIN_COUNT-1:0] pins;         // raw pin vector
   logic spiOn;                         // spi link live
   logic i2cOn;                         // i2c link live
   logic sclkRise;                      // sclk rising edge
   logic sclkFall;                      // sclk falling edge
   logic sclRise;                       // scl rising edge
   logic sclFall;                       // scl falling edge
   logic startCond;                     // sda falls while scl high
   logic stopCond;                      // sda rises while scl high
   logic push;                          // write request into buffer
   logic [`REQ_WORD_BITS-1:0] pushWord; // request word offered
   logic fifoInReady;                   // buffer has room
   logic [`REQ_WORD_BITS-1:0] fifoOut;  // oldest request

   // true when an i2c byte carries our own address
   function automatic logic ownAddress(input logic [7:0] b);
      ownAddress = (b[7:1] == `I2C_OWN_ADDR);
   endfunction : ownAddress

   // gather the pins that come from outside this clock
   assign pins = {ifSelect, sdaIn, scl, spiSelectN, mosi, sclk};

   // link gating by strap and soft start
   assign spiOn = st.modeValid && st.mode == MODE_SPI && portEnable;
   assign i2cOn = st.modeValid && st.mode == MODE_I2C && portEnable;

   // edges of the agreed pin levels
   assign sclkRise = st.filt[`PIN_SCLK] && !st.prev[`PIN_SCLK];
   assign sclkFall = !st.filt[`PIN_SCLK] && st.prev[`PIN_SCLK];
   assign sclRise = st.filt[`PIN_SCL] && !st.prev[`PIN_SCL];
   assign sclFall = !st.filt[`PIN_SCL] && st.prev[`PIN_SCL];

   // start and stop need scl high both before and now
   assign startCond = st.filt[`PIN_SCL] && st.prev[`PIN_SCL]
      && st.prev[`PIN_SDA] && !st.filt[`PIN_SDA];
   assign stopCond = st.filt[`PIN_SCL] && st.prev[`PIN_SCL]
      && !st.prev[`PIN_SDA] && st.filt[`PIN_SDA];

   // pin drivers: sda value tied low, the rest from flops except the miso enable
   assign misoOut = st.misoBit;
   assign misoOeN = !(spiOn && !st.filt[`PIN_SEL]);
   assign sdaOut = 1'b0;
   assign sdaOeN = !st.sdaLow;
   assign rdAddr = st.rdAddr;
   assign spiOverrun = st.spiOverrun;
   assign ifMode = st.mode;
   assign reqAddr = fifoOut[15:8];
   assign reqData = fifoOut[7:0];

   // next-state logic for synchronisers, strap, spi and i2c
   always_comb begin
      next_st = st;
      push = 1'b0;
      pushWord = '0;
      next_st.spiOverrun = 1'b0;

      // three-stage synchroniser; a level counts once stages two and three agree
      next_st.sync1 = pins;
      next_st.sync2 = st.sync1;
      next_st.sync3 = st.sync2;
      next_st.prev = st.filt;
      for (int i = 0; i < `PIN_COUNT; i++) begin
         if (st.sync2[i] == st.sync3[i]) begin
            next_st.filt[i] = st.sync3[i];
         end
      end

      // strap is caught once after the chain settles, then frozen
      if (!st.modeValid) begin
         if (st.strapCnt == `STRAP_WAIT) begin
            next_st.modeValid = 1'b1;
            next_st.mode = st.filt[`PIN_IFS] ? MODE_SPI : MODE_I2C;
         end else begin
            next_st.strapCnt = st.strapCnt + 1'b1;
         end
      end

      // a frame cut short by select leaves nothing behind but rdAddr
      // spi slave: select high holds the frame logic in reset
      if (!spiOn || st.filt[`PIN_SEL]) begin
         next_st.spiCnt = '0;
         next_st.misoBit = 1'b0;
         next_st.spiRead = 1'b0;
      end else begin
         // capture on rising sclk, extra clocks past the frame are ignored
         if (sclkRise && st.spiCnt != `SPI_FRAME_BITS) begin
            next_st.spiShift = {st.spiShift[14:0], st.filt[`PIN_MOSI]};
            next_st.spiCnt = st.spiCnt + 1'b1;
            if (st.spiCnt == `SPI_ADDR_DONE) begin
               // eighth bit is the direction, zero reads
               next_st.spiRead = !st.filt[`PIN_MOSI];
               next_st.rdAddr = {1'b0, st.spiShift[6:0]};
            end
            if (st.spiCnt == `SPI_LAST_BIT && !st.spiRead) begin
               // last bit of a write frame completes one register write
               if (fifoInReady) begin
                  push = 1'b1;
                  pushWord = {1'b0, st.spiShift[14:8], st.spiShift[6:0], st.filt[`PIN_MOSI]};
               end else begin
                  next_st.spiOverrun = 1'b1;
               end
            end
         end
         // change miso on falling sclk during the read data phase
         if (sclkFall && st.spiRead) begin
            if (st.spiCnt == `SPI_DATA_START) begin
               next_st.misoBit = rdData[7];
               next_st.spiOut = {rdData[6:0], 1'b0};
            end else if (st.spiCnt > `SPI_DATA_START) begin
               // zero shifts in, so miso returns low after bit zero
               next_st.misoBit = st.spiOut[7];
               next_st.spiOut = {st.spiOut[6:0], 1'b0};
            end
         end
      end

      // i2c slave
      // sda is only ever pulled low; a released wire rests on its pull-up
      if (!i2cOn || stopCond) begin
         // stop or sda rising during scl high ends the transaction
         next_st.i2cSt = I2C_IDLE;
         next_st.sdaLow = 1'b0;
      end else if (startCond) begin
         // a start, first or repeated, opens a new address phase
         next_st.i2cSt = I2C_RECV;
         next_st.bitCnt = '0;
         next_st.phase = '0;
         next_st.sdaLow = 1'b0;
      end else begin
         case (st.i2cSt)
            I2C_RECV: begin
               if (sclRise && st.bitCnt != `I2C_BYTE_BITS) begin
                  // sample in the high half, msb first
                  next_st.shift = {st.shift[6:0], st.filt[`PIN_SDA]};
                  next_st.bitCnt = st.bitCnt + 1'b1;
               end else if (sclFall && st.bitCnt == `I2C_BYTE_BITS) begin
                  next_st.i2cSt = I2C_ACK;
                  case (st.phase)
                     2'h0: begin
                        // slave address byte
                        if (ownAddress(st.shift)) begin
                           next_st.sdaLow = 1'b1;
                           next_st.isRead = st.shift[0];
                        end else begin
                           next_st.i2cSt = I2C_IDLE;
                        end
                     end
                     2'h1: begin
                        // register address byte, held for a later read
                        next_st.rdAddr = st.shift;
                        next_st.sdaLow = 1'b1;
                     end
                     2'h2: begin
                        // data byte; a full buffer refuses it with a nack
                        if (fifoInReady) begin
                           push = 1'b1;
                           pushWord = {st.rdAddr, st.shift};
                           next_st.sdaLow = 1'b1;
                        end else begin
                           next_st.i2cSt = I2C_IDLE;
                        end
                     end
                     default: begin
                        // no auto-increment: further bytes get a nack
                        next_st.i2cSt = I2C_IDLE;
                     end
                  endcase
               end
            end
            I2C_ACK: begin
               // hold sda low through the ninth clock, release on its fall
               if (sclFall) begin
                  next_st.sdaLow = 1'b0;
                  next_st.bitCnt = '0;
                  if (st.isRead && st.phase == 2'h0) begin
                     // become transmitter, first bit out now
                     next_st.i2cSt = I2C_SEND;
                     next_st.sdaLow = !rdData[7];
                     next_st.shift = {rdData[6:0], 1'b0};
                     next_st.bitCnt = 4'h1;
                  end else begin
                     next_st.i2cSt = I2C_RECV;
                     next_st.phase = st.phase + 1'b1;
                  end
               end
            end
            I2C_SEND: begin
               // new bit on each scl fall, release for the master's ack
               if (sclFall) begin
                  if (st.bitCnt == `I2C_BYTE_BITS) begin
                     next_st.sdaLow = 1'b0;
                     next_st.i2cSt = I2C_MACK;
                  end else begin
                     next_st.sdaLow = !st.shift[7];
                     next_st.shift = {st.shift[6:0], 1'b0};
                     next_st.bitCnt = st.bitCnt + 1'b1;
                  end
               end
            end
            I2C_MACK: begin
               // one byte per read; ack or nack, wait for the stop
               if (sclRise) begin
                  next_st.i2cSt = I2C_IDLE;
               end
            end
            default: begin
               // idle waits for a start
               next_st.sdaLow = 1'b0;
            end
         endcase
      end
   end

   // state register
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // write request buffer; a full buffer stalls i2c with a nack
   req_fifo #(
      .WIDTH(`REQ_WORD_BITS),
      .DEPTH(FIFO_DEPTH)
   ) u_req_fifo (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .inValid(push),
      .inReady(fifoInReady),
      .inData(pushWord),
      .outValid(reqValid),
      .outReady(reqReady),
      .outData(fifoOut)
   );

   // checks on the port's own behaviour
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!arst_n);

   a_strap_frozen: assert property (st.modeValid && $past(st.modeValid) |-> $stable(st.mode))
      else $error("link choice changed after capture");
   a_miso_unselected: assert property (st.filt[`PIN_SEL] |-> misoOeN)
      else $error("miso driven while select high");
   a_miso_low_write: assert property (!misoOeN && !st.spiRead |-> !misoOut)
      else $error("miso not low outside read data");
   a_spi_push_frame: assert property (spiOn && push |-> st.spiCnt == 5'h0f && sclkRise)
      else $error("spi write pushed outside sixteenth edge");
   a_select_reset: assert property (spiOn && st.filt[`PIN_SEL] |=> st.spiCnt == '0)
      else $error("spi bit count not cleared by select");
   a_start_opens: assert property (i2cOn && startCond && !stopCond
      |=> st.i2cSt == I2C_RECV && st.bitCnt == '0 && st.phase == '0)
      else $error("start did not open address phase");
   a_stop_release: assert property (stopCond |=> sdaOeN && st.i2cSt == I2C_IDLE)
      else $error("stop did not release sda");
   a_ack_drives: assert property (st.i2cSt == I2C_ACK |-> !sdaOeN)
      else $error("ack state without sda low");
   a_mismatch_idle: assert property (i2cOn && st.i2cSt == I2C_RECV && st.phase == '0
      && sclFall && st.bitCnt == 4'h8 && !ownAddress(st.shift) && !startCond && !stopCond
      |=> st.i2cSt == I2C_IDLE ##1 sdaOeN)
      else $error("foreign address acknowledged");
   // miso enable follows the gate at once, the sda flop one cycle later
   a_disabled_quiet: assert property (!portEnable |-> misoOeN ##1 sdaOeN)
      else $error("port active before soft start");

   // spi link: direction decode and writes lost to a full buffer
   a_dir_decode: assert property (spiOn && !st.filt[`PIN_SEL] && sclkRise
      && st.spiCnt == 5'h07 |=> st.spiRead == !$past(st.filt[`PIN_MOSI]))
      else $error("spi direction bit decoded wrongly");
   a_overrun_flag: assert property (spiOn && !st.filt[`PIN_SEL] && sclkRise
      && st.spiCnt == 5'h0f && !st.spiRead && !fifoInReady |=> spiOverrun)
      else $error("lost spi write not flagged");

   // i2c link: idle release, no address increment, read launch
   a_idle_released: assert property (st.i2cSt == I2C_IDLE |=> sdaOeN)
      else $error("sda pulled while idle");
   a_no_increment: assert property (i2cOn && st.i2cSt == I2C_RECV && st.phase == 2'h3
      && sclFall && st.bitCnt == 4'h8 && !startCond && !stopCond
      |=> st.i2cSt == I2C_IDLE && sdaOeN)
      else $error("byte past the data byte acknowledged");
   a_send_first: assert property (i2cOn && st.i2cSt == I2C_ACK && st.isRead
      && st.phase == 2'h0 && sclFall && !startCond && !stopCond
      |=> st.i2cSt == I2C_SEND && sdaOeN == $past(rdData[7]))
      else $error("read data not launched after address ack");

   // scenario coverage

   c_spi_write: cover property (spiOn && push);
   c_spi_read: cover property (spiOn && st.spiRead && st.spiCnt == 5'h0c && !misoOeN);
   c_i2c_write: cover property (i2cOn && push);
   c_i2c_read: cover property (st.i2cSt == I2C_SEND ##[1:400] st.i2cSt == I2C_MACK);
   c_restart: cover property (i2cOn && st.i2cSt == I2C_RECV && st.phase == 2'h2 && startCond);

endmodule : dual_serial_host_register_port

/* rtl/req_fifo.sv */
// small first-in first-out buffer for register write requests
`timescale 1ns/10ps
`include "serial_port_consts.svh"
module req_fifo #(
   parameter int WIDTH = `REQ_WORD_BITS,  // word width
   parameter int DEPTH = `REQ_FIFO_DEPTH  // words held
) (
   input wire logic core_clk,             // system clock
   input wire logic arst_n,               // asynchronous reset, active low
   input wire logic inValid,              // writer offers a word
   output logic inReady,                  // room for a word
   input wire logic [WIDTH-1:0] inData,   // offered word
   output logic outValid,                 // a word is waiting
   input wire logic outReady,             // reader takes the word
   output logic [WIDTH-1:0] outData       // oldest word
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   // refuse depths the pointer wrap cannot serve
   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad
      $error("req_fifo depth must be a power of two of at least 2");
   end

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem; // stored words
      logic [AW-1:0] wrPtr;             // next free slot
      logic [AW-1:0] rdPtr;             // oldest slot
      logic [AW:0] count;               // words held
   } fifo_state_s;

   fifo_state_s st;      // registered state
   fifo_state_s next_st; // next state
   logic doPush;         // word enters
   logic doPop;          // word leaves

   // honest full and empty straight from the count
   assign inReady = (st.count != (AW + 1)'(DEPTH));
   assign outValid = (st.count != '0);
   assign outData = st.mem[st.rdPtr];

   // pointer and count update
   always_comb begin
      next_st = st;
      doPush = inValid && inReady;
      doPop = outValid && outReady;
      if (doPush) begin
         next_st.mem[st.wrPtr] = inData;
         next_st.wrPtr = st.wrPtr + 1'b1;
      end
      if (doPop) begin
         next_st.rdPtr = st.rdPtr + 1'b1;
      end
      if (doPush && !doPop) begin
         next_st.count = st.count + 1'b1;
      end else if (doPop && !doPush) begin
         next_st.count = st.count - 1'b1;
      end
   end

   // state register
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

endmodule : req_fifo

/* rtl/serial_port_consts.svh */
// constants for the dual-link serial register port
`ifndef SERIAL_PORT_CONSTS_SVH
`define SERIAL_PORT_CONSTS_SVH

// pin positions inside the synchroniser vectors
`define PIN_SCLK 0
`define PIN_MOSI 1
`define PIN_SEL 2
`define PIN_SCL 3
`define PIN_SDA 4
`define PIN_IFS 5
`define PIN_COUNT 6

// spi frame layout: 7 address bits, 1 direction bit, 8 data bits
`define SPI_FRAME_BITS 5'h10
`define SPI_ADDR_DONE 5'h07
`define SPI_DATA_START 5'h08
`define SPI_LAST_BIT 5'h0f

// i2c byte length and own 7-bit slave address
`define I2C_BYTE_BITS 4'h8
`define I2C_OWN_ADDR 7'h2d

// core clocks after reset before the strap level is trusted
`define STRAP_WAIT 3'h5

// write request buffer depth and word width (register address + data)
`define REQ_FIFO_DEPTH 4
`define REQ_WORD_BITS 16

`endif

/* rtl/serial_port_pkg.sv */
// types shared by the dual-link serial register port
package serial_port_pkg;

   // link picked by the strap pin
   typedef enum logic {MODE_I2C, MODE_SPI} port_mode_e;

   // i2c slave sequencing
   typedef enum logic [2:0] {I2C_IDLE, I2C_RECV, I2C_ACK, I2C_SEND, I2C_MACK} i2c_state_e;

   // complete state of the port
   typedef struct packed {
      logic [5:0] sync1;     // first synchroniser stage
      logic [5:0] sync2;     // second stage
      logic [5:0] sync3;     // third stage
      logic [5:0] filt;      // agreed pin level
      logic [5:0] prev;      // agreed level one cycle back
      logic [2:0] strapCnt;  // settle counter for the strap
      logic modeValid;       // strap captured
      port_mode_e mode;      // captured link
      logic [4:0] spiCnt;    // rising sclk edges in frame
      logic [15:0] spiShift; // incoming frame bits
      logic spiRead;         // frame is a read
      logic [7:0] spiOut;    // outgoing read data
      logic misoBit;         // level driven on miso
      logic spiOverrun;      // write lost to a full buffer
      i2c_state_e i2cSt;     // i2c sequencer state
      logic [1:0] phase;     // byte index inside transaction
      logic [3:0] bitCnt;    // bit index inside byte
      logic [7:0] shift;     // i2c byte shifter
      logic isRead;          // addressed for reading
      logic sdaLow;          // pulling sda low
      logic [7:0] rdAddr;    // selected register
   } port_state_s;

endpackage : serial_port_pkg

/* verification/serial_host.sv */
// host model: spi and i2c master on the port's link pins
`timescale 1ns/10ps
module serial_host (
   input wire logic clk,     // core clock paces the pins
   input wire logic misoOut, // device miso value
   input wire logic misoOeN, // device drives miso while low
   input wire logic sdaOut,  // device sda value
   input wire logic sdaOeN,  // device pulls sda while low
   output logic sclk,        // spi clock
   output logic mosi,        // spi data
   output logic selN,        // spi select, active low
   output logic scl,         // i2c clock
   output logic sdaIn        // resolved sda wire
);
   logic sdaDrv; // master side of the open-drain wire
   logic miso;   // released miso shows the inverse, never a held value
   assign sdaIn = sdaDrv & (sdaOeN | sdaOut);
   assign miso = misoOeN ? ~misoOut : misoOut;
   initial begin
      {sclk, mosi, selN, scl, sdaDrv} = 5'b00111;
   end
   task automatic w(input int n);
      repeat (n) @(negedge clk);
   endtask : w
   // n bits of a frame, msb first; miso read late in the high phase
   task automatic spi(input logic [15:0] f, input int n, output logic [15:0] rd);
      rd = 16'h0000;
      selN = 1'b0;
      for (int i = 15; i > 15 - n; i--) begin
         mosi = f[i];
         w(4);
         sclk = 1'b1;
         w(3);
         rd[i] = miso;
         w(1);
         sclk = 1'b0;
      end
      w(4);
      selN = 1'b1;
      mosi = ~mosi;
      w(8);
   endtask : spi
   // start or repeated start
   task automatic i2c_start();
      sdaDrv = 1'b1;
      w(6);
      scl = 1'b1;
      w(12);
      sdaDrv = 1'b0;
      w(12);
      scl = 1'b0;
   endtask : i2c_start
   task automatic i2c_stop();
      sdaDrv = 1'b0;
      w(6);
      scl = 1'b1;
      w(12);
      sdaDrv = 1'b1;
      w(12);
   endtask : i2c_stop
   // eight bits plus the acknowledge slot; sda only moves while scl is low
   task automatic i2c_byte(input logic [8:0] tx, output logic [8:0] rx);
      for (int i = 8; i >= 0; i--) begin
         w(6);
         sdaDrv = tx[i];
         w(6);
         scl = 1'b1;
         w(11);
         rx[i] = sdaIn;
         w(1);
         scl = 1'b0;
      end
   endtask : i2c_byte
endmodule : serial_host

/* verification/tb_top.sv */
// self-checking bench for the dual-link serial register port
`timescale 1ns/10ps
module tb_top;
   import serial_port_pkg::*;
   logic core_clk = 1'b0;
   logic arst_n = 1'b0;
   logic ifSelect = 1'b1;
   logic portEnable = 1'b1;
   logic reqReady = 1'b0;
   logic sclk, mosi, spiSelectN, misoOut, misoOeN, scl, sdaIn, sdaOut, sdaOeN;
   logic reqValid, spiOverrun;
   logic [7:0] rdAddr, rdData, reqAddr, reqData;
   port_mode_e ifMode;
   logic [15:0] rd;
   logic [8:0] rx;
   int fails = 0;
   int n_tests = 0;
   int ovCnt = 0;
   int cyc = 0;
   // frame, expected {address, data}
   logic [31:0] rows [5] = '{32'h25a5_12a5, 32'hff01_7f01, 32'h2400_12d1,
                             32'haa00_5596, 32'h0000_00c3};
   logic [7:0] wr [4] = '{8'h5a, 8'h34, 8'h9e, 8'h77};
   assign rdData = rdAddr ^ 8'hc3; // register file stand-in
   always #5 core_clk = ~core_clk;
   // overrun pulses and hang guard
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (spiOverrun === 1'b1) ovCnt <= ovCnt + 1;
      if (cyc == 30000) begin
         fails = fails + 1;
         finish_test();
      end
   end
   dual_serial_host_register_port #(.FIFO_DEPTH(4)) dut (.core_clk(core_clk),
      .arst_n(arst_n), .ifSelect(ifSelect), .portEnable(portEnable), .sclk(sclk),
      .mosi(mosi), .spiSelectN(spiSelectN), .misoOut(misoOut), .misoOeN(misoOeN),
      .scl(scl), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOeN(sdaOeN), .rdAddr(rdAddr),
      .rdData(rdData), .reqValid(reqValid), .reqReady(reqReady), .reqAddr(reqAddr),
      .reqData(reqData), .spiOverrun(spiOverrun), .ifMode(ifMode));
   serial_host host (.clk(core_clk), .misoOut(misoOut), .misoOeN(misoOeN),
      .sdaOut(sdaOut), .sdaOeN(sdaOeN), .sclk(sclk), .mosi(mosi), .selN(spiSelectN),
      .scl(scl), .sdaIn(sdaIn));
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : finish_test
   // wait for a request, compare, take it
   task automatic pop(input logic [15:0] exp);
      for (int i = 0; i < 40 && reqValid !== 1'b1; i++) @(negedge core_clk);
      chk({15'h0, reqValid}, 16'h0001);
      chk({reqAddr, reqData}, exp);
      reqReady = 1'b1;
      @(negedge core_clk);
      reqReady = 1'b0;
   endtask : pop
   task automatic do_reset(input logic sel);
      arst_n = 1'b0;
      ifSelect = sel;
      repeat (8) @(negedge core_clk);
      arst_n = 1'b1;
      repeat (12) @(negedge core_clk);
   endtask : do_reset
   initial begin
      do_reset(1'b1);
      chk({15'h0, ifMode}, {15'h0, MODE_SPI});
      chk({15'h0, misoOeN}, 16'h0001);
      ifSelect = 1'b0;
      foreach (rows[k]) begin
         host.spi(rows[k][31:16], 16, rd);
         if (rows[k][24]) begin
            chk(rd, 16'h0000);
            pop(rows[k][15:0]);
         end else begin
            chk(rd, {8'h00, rows[k][7:0]});
            chk({8'h00, rdAddr}, {8'h00, rows[k][15:8]});
         end
         chk({15'h0, misoOeN}, 16'h0001);
         $display("spi row %0d done", k);
      end
      chk({15'h0, ifMode}, {15'h0, MODE_SPI});
      // cut frame, then a whole one
      host.spi(16'hffff, 8, rd);
      host.spi(16'h0b3c, 16, rd);
      pop(16'h053c);
      chk({15'h0, reqValid}, 16'h0000);
      // fill the buffer past full with the consumer stalled
      for (int k = 0; k < 5; k++) host.spi({7'(k), 1'b1, 8'(8'h40 + k)}, 16, rd);
      chk(16'(ovCnt), 16'h0001);
      for (int k = 0; k < 4; k++) pop({8'(k), 8'(8'h40 + k)});
      chk({15'h0, reqValid}, 16'h0000);
      portEnable = 1'b0;
      host.spi(16'h0b3c, 16, rd);
      chk({15'h0, reqValid}, 16'h0000);
      portEnable = 1'b1;
      $display("spi edge cases done");
      do_reset(1'b0);
      chk({15'h0, ifMode}, {15'h0, MODE_I2C});
      host.i2c_start();
      foreach (wr[k]) begin
         host.i2c_byte({wr[k], 1'b1}, rx);
         chk({15'h0, rx[0]}, {15'h0, k == 3});
      end
      host.i2c_stop();
      pop(16'h349e);
      host.i2c_start();
      host.i2c_byte(9'h0b5, rx);
      host.i2c_byte(9'h043, rx);
      host.i2c_start();
      host.i2c_byte(9'h0b7, rx);
      chk({15'h0, rx[0]}, 16'h0000);
      host.i2c_byte(9'h1ff, rx);
      host.i2c_stop();
      chk({7'h00, rx}, {7'h00, 8'he2, 1'b1});
      chk({8'h00, rdAddr}, 16'h0021);
      $display("i2c write and read done");
      host.i2c_start();
      host.i2c_byte(9'h0b9, rx);
      chk({15'h0, rx[0]}, 16'h0001);
      host.i2c_byte(9'h069, rx);
      chk({15'h0, rx[0]}, 16'h0001);
      host.i2c_stop();
      host.i2c_start();
      host.i2c_byte(9'h0b5, rx);
      host.i2c_stop();
      host.scl = 1'b0;
      host.i2c_byte(9'h069, rx);
      chk({15'h0, rx[0]}, 16'h0001);
      host.i2c_byte(9'h13d, rx);
      chk({15'h0, rx[0]}, 16'h0001);
      host.i2c_stop();
      chk({15'h0, sdaOeN}, 16'h0001);
      chk({15'h0, reqValid}, 16'h0000);
      $display("i2c refusals done");
      finish_test();
   end
endmodule : tb_top
